// *** src/dtc_pkg.sv ***
package dtc_pkg;

  typedef enum logic [1:0] {
    DTC_RLD16  = 2'h0,
    DTC_FREE16 = 2'h1,
    DTC_RLD8   = 2'h2,
    DTC_SPLIT  = 2'h3
  } dtc_mode_t;

  localparam logic [7:0] DTC_OFS_RUN  = 8'h00;
  localparam logic [7:0] DTC_OFS_OUT  = 8'h04;
  localparam logic [7:0] DTC_OFS_MODE = 8'h08;
  localparam logic [7:0] DTC_OFS_TL0  = 8'h0C;
  localparam logic [7:0] DTC_OFS_TH0  = 8'h10;
  localparam logic [7:0] DTC_OFS_TL1  = 8'h14;
  localparam logic [7:0] DTC_OFS_TH1  = 8'h18;

  // Run/flag register fields
  localparam int DTC_TF1 = 7;
  localparam int DTC_TR1 = 6;
  localparam int DTC_TF0 = 5;
  localparam int DTC_TR0 = 4;
  // Output/prescale register fields
  localparam int DTC_OE1  = 5;
  localparam int DTC_X121 = 4;
  localparam int DTC_OE0  = 1;
  localparam int DTC_X120 = 0;
  localparam logic [7:0] DTC_OUT_MASK = 8'h33;
  // Mode register fields, per timer nibble
  localparam int DTC_MODE_LSB = 0;
  localparam int DTC_CT_BIT   = 2;
  localparam int DTC_GATE_BIT = 3;
  localparam int DTC_NIB      = 4;

  localparam logic [7:0]  DTC_RST8  = 8'h00;
  localparam logic [15:0] DTC_RST16 = 16'h0000;
  localparam logic [7:0]  DTC_MAX8  = 8'hFF;
  localparam logic [15:0] DTC_MAX16 = 16'hFFFF;

  localparam int          DTC_DIV      = 12;
  localparam logic [3:0]  DTC_PRE_LAST = 4'(DTC_DIV - 1);

endpackage : dtc_pkg

// *** src/dtc_timer_pair.sv ***
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module dtc_timer_pair
  import dtc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  cntPin,
  input  wire logic [1:0]  gatePin,
  input  wire logic [1:0]  intAck,
  output logic      [1:0]  ovfFlag,
  output logic      [1:0]  tmrOut
);

  typedef struct packed {
    logic [1:0]       cS1;
    logic [1:0]       cS2;
    logic [1:0]       cS3;
    logic [1:0]       gS1;
    logic [1:0]       gS2;
    logic [3:0]       pre;
    logic [1:0]       run;
    logic [1:0]       flag;
    logic [7:0]       outCtl;
    logic [7:0]       timer_mode_select;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] rel;
    logic [1:0][7:0]  stg;
    logic [1:0]       pin;
    logic [31:0]      rdata;
    logic             rdy;
    logic             err;
  } dtc_state_t;

  dtc_state_t s_q;
  dtc_state_t s_d;
  logic [2:0] ovf;
  logic [1:0] fall;
  logic       wrEn;
  logic       split;

  function automatic logic dtcMapped(input logic [7:0] a);
    dtcMapped = (a == DTC_OFS_RUN) || (a == DTC_OFS_OUT) ||
                (a == DTC_OFS_MODE) || (a == DTC_OFS_TL0) ||
                (a == DTC_OFS_TH0) || (a == DTC_OFS_TL1) ||
                (a == DTC_OFS_TH1);
  endfunction : dtcMapped

  function automatic dtc_mode_t dtcMode(input logic [7:0] t,
                                        input int i);
    dtcMode = dtc_mode_t'(t[i*DTC_NIB+DTC_MODE_LSB +: 2]);
  endfunction : dtcMode

  // One count step; the top bit is the overflow event
  function automatic logic [16:0] dtcStep(input dtc_mode_t m,
                                          input logic [15:0] c,
                                          input logic [15:0] r);
    case (m)
      DTC_RLD16: dtcStep = (c == DTC_MAX16) ? {1'b1, r} :
                           {1'b0, c + 16'h0001};
      DTC_FREE16: dtcStep = {c == DTC_MAX16, c + 16'h0001};
      DTC_RLD8: dtcStep = (c[7:0] == DTC_MAX8) ?
                          {1'b1, c[15:8], c[15:8]} :
                          {1'b0, c[15:8], c[7:0] + 8'h01};
      default: dtcStep = {1'b0, c};
    endcase
  endfunction : dtcStep

  assign wrEn  = psel & penable & s_q.rdy & pwrite;
  assign split = dtcMode(s_q.timer_mode_select, 0) == DTC_SPLIT;
  // Only the settled stages feed the edge detector
  assign fall  = s_q.cS3 & ~s_q.cS2;

  always_comb begin
    logic [1:0]  sysTk;
    logic [1:0]  tk;
    logic [1:0]  go;
    logic [1:0]  hwSet;
    logic [16:0] st;
    logic [7:0]  wd;
    logic        tIdx;
    logic        en1;
    sysTk = '0;
    tk    = '0;
    go    = '0;
    hwSet = '0;
    st    = '0;
    wd    = pwdata[7:0];
    tIdx  = 1'b0;
    en1   = 1'b0;
    ovf   = '0;
    s_d   = s_q;

    s_d.cS1 = cntPin;
    s_d.cS2 = s_q.cS1;
    s_d.cS3 = s_q.cS2;
    s_d.gS1 = gatePin;
    s_d.gS2 = s_q.gS1;
    s_d.pre = (s_q.pre == DTC_PRE_LAST) ? 4'h0 : s_q.pre + 4'h1;

    for (int i = 0; i < 2; i++) begin
      sysTk[i] = s_q.outCtl[i*DTC_NIB] ? 1'b1 :
                 (s_q.pre == DTC_PRE_LAST);
      tk[i] = s_q.timer_mode_select[i*DTC_NIB+DTC_CT_BIT] ? fall[i] : sysTk[i];
      go[i] = s_q.run[i] &
              (~s_q.timer_mode_select[i*DTC_NIB+DTC_GATE_BIT] | s_q.gS2[i]);
    end

    // Timer 0; count is never cleared by starting
    if (split) begin
      if (go[0] & tk[0]) begin
        ovf[0] = s_q.cnt[0][7:0] == DTC_MAX8;
        s_d.cnt[0][7:0] = s_q.cnt[0][7:0] + 8'h01;
      end
      if (s_q.run[1] & sysTk[0]) begin
        ovf[1] = s_q.cnt[0][15:8] == DTC_MAX8;
        s_d.cnt[0][15:8] = s_q.cnt[0][15:8] + 8'h01;
      end
    end else if (go[0] & tk[0]) begin
      st = dtcStep(dtcMode(s_q.timer_mode_select, 0), s_q.cnt[0], s_q.rel[0]);
      ovf[0] = st[16];
      s_d.cnt[0] = st[15:0];
    end

    // Timer 1; mode 3 stops it, split steals its run bit
    if (split) begin
      en1 = sysTk[1];
    end else begin
      en1 = go[1] & tk[1];
    end
    if (en1 && dtcMode(s_q.timer_mode_select, 1) != DTC_SPLIT) begin
      st = dtcStep(dtcMode(s_q.timer_mode_select, 1), s_q.cnt[1], s_q.rel[1]);
      ovf[2] = st[16];
      s_d.cnt[1] = st[15:0];
    end

    hwSet[0] = ovf[0];
    hwSet[1] = split ? ovf[1] : ovf[2];
    s_d.pin[0] = s_q.pin[0] ^ (ovf[0] & s_q.outCtl[DTC_OE0]);
    s_d.pin[1] = s_q.pin[1] ^ (ovf[2] & s_q.outCtl[DTC_OE1]);

    // Hardware set wins over ack and software clear
    s_d.flag = hwSet | (s_q.flag & ~intAck);

    if (wrEn) begin
      if (paddr == DTC_OFS_RUN) begin
        s_d.run  = {pwdata[DTC_TR1], pwdata[DTC_TR0]};
        s_d.flag = hwSet |
                   ({pwdata[DTC_TF1], pwdata[DTC_TF0]} & ~intAck);
      end else if (paddr == DTC_OFS_OUT) begin
        s_d.outCtl = wd & DTC_OUT_MASK;
      end else if (paddr == DTC_OFS_MODE) begin
        s_d.timer_mode_select = wd;
      end else if (paddr == DTC_OFS_TL0 || paddr == DTC_OFS_TL1) begin
        tIdx = paddr == DTC_OFS_TL1;
        if (dtcMode(s_q.timer_mode_select, int'(tIdx)) == DTC_RLD16) begin
          // Low write commits the staged high byte
          s_d.rel[tIdx] = {s_q.stg[tIdx], wd};
          if (!s_q.run[tIdx]) begin
            s_d.cnt[tIdx] = {s_q.stg[tIdx], wd};
          end
        end else begin
          s_d.cnt[tIdx][7:0] = wd;
        end
      end else if (paddr == DTC_OFS_TH0 || paddr == DTC_OFS_TH1) begin
        tIdx = paddr == DTC_OFS_TH1;
        if (dtcMode(s_q.timer_mode_select, int'(tIdx)) == DTC_RLD16) begin
          s_d.stg[tIdx] = wd;
        end else begin
          s_d.cnt[tIdx][15:8] = wd;
        end
      end
    end

    // Zero-wait slave: answer one cycle after setup
    s_d.rdy   = psel & ~penable;
    s_d.err   = psel & ~penable & ~dtcMapped(paddr);
    s_d.rdata = '0;
    if (psel & ~penable & ~pwrite) begin
      if (paddr == DTC_OFS_RUN) begin
        s_d.rdata[DTC_TF1] = s_q.flag[1];
        s_d.rdata[DTC_TR1] = s_q.run[1];
        s_d.rdata[DTC_TF0] = s_q.flag[0];
        s_d.rdata[DTC_TR0] = s_q.run[0];
      end else if (paddr == DTC_OFS_OUT) begin
        s_d.rdata[7:0] = s_q.outCtl & DTC_OUT_MASK;
      end else if (paddr == DTC_OFS_MODE) begin
        s_d.rdata[7:0] = s_q.timer_mode_select;
      end else if (paddr == DTC_OFS_TL0) begin
        s_d.rdata[7:0] = s_q.cnt[0][7:0];
      end else if (paddr == DTC_OFS_TH0) begin
        s_d.rdata[7:0] = s_q.cnt[0][15:8];
      end else if (paddr == DTC_OFS_TL1) begin
        s_d.rdata[7:0] = s_q.cnt[1][7:0];
      end else if (paddr == DTC_OFS_TH1) begin
        s_d.rdata[7:0] = s_q.cnt[1][15:8];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.rdata;
  assign pready  = s_q.rdy;
  assign pslverr = s_q.err;
  assign ovfFlag = s_q.flag;
  assign tmrOut  = s_q.pin;

  default clocking dtcClk @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_FLAG_SET: assert property (
    ovf[0]
    |=> s_q.flag[0])
    else $error("overflow did not set flag 0");

  AST_FLAG1_SET: assert property (
    (split ? ovf[1] : ovf[2])
    |=> s_q.flag[1])
    else $error("overflow did not set flag 1");

  AST_ACK_CLEAR: assert property (
    intAck[0] && !ovf[0] && !wrEn
    |=> !s_q.flag[0])
    else $error("ack did not clear flag 0");

  AST_ACK1_CLEAR: assert property (
    intAck[1] && !(split ? ovf[1] : ovf[2]) && !wrEn
    |=> !s_q.flag[1])
    else $error("ack did not clear flag 1");

  AST_RELOAD16: assert property (
    !split && dtcMode(s_q.timer_mode_select, 0) == DTC_RLD16 && ovf[0] && !wrEn
    |=> s_q.cnt[0] == $past(s_q.rel[0]))
    else $error("mode 0 overflow did not reload");

  AST_RELOAD16_T1: assert property (
    !split && dtcMode(s_q.timer_mode_select, 1) == DTC_RLD16 && ovf[2] && !wrEn
    |=> s_q.cnt[1] == $past(s_q.rel[1]))
    else $error("timer 1 mode 0 overflow did not reload");

  AST_STAGE_COMMIT: assert property (
    dtcMode(s_q.timer_mode_select, 0) == DTC_RLD16 && wrEn && paddr == DTC_OFS_TL0
    |=> s_q.rel[0] == {$past(s_q.stg[0]), $past(pwdata[7:0])})
    else $error("low write did not commit staged high byte");

  AST_STOP_LOAD: assert property (
    dtcMode(s_q.timer_mode_select, 0) == DTC_RLD16 && !s_q.run[0] && wrEn &&
    paddr == DTC_OFS_TL0
    |=> s_q.cnt[0] == s_q.rel[0])
    else $error("stopped low write did not load count");

  AST_FREE_WRAP: assert property (
    dtcMode(s_q.timer_mode_select, 1) == DTC_FREE16 && !split && ovf[2] && !wrEn
    |=> s_q.cnt[1] == DTC_RST16)
    else $error("mode 1 overflow did not wrap to zero");

  AST_FREE_WRAP0: assert property (
    dtcMode(s_q.timer_mode_select, 0) == DTC_FREE16 && !split && ovf[0] && !wrEn
    |=> s_q.cnt[0] == DTC_RST16)
    else $error("timer 0 mode 1 overflow did not wrap");

  AST_RLD8: assert property (
    dtcMode(s_q.timer_mode_select, 1) == DTC_RLD8 && !split && ovf[2] && !wrEn
    |=> s_q.cnt[1][7:0] == s_q.cnt[1][15:8])
    else $error("mode 2 overflow did not copy reload byte");

  AST_RLD8_T0: assert property (
    dtcMode(s_q.timer_mode_select, 0) == DTC_RLD8 && !split && ovf[0] && !wrEn
    |=> s_q.cnt[0][7:0] == s_q.cnt[0][15:8])
    else $error("timer 0 mode 2 overflow did not reload");

  AST_RLD8_HOLD: assert property (
    dtcMode(s_q.timer_mode_select, 0) == DTC_RLD8 && !wrEn
    |=> $stable(s_q.cnt[0][15:8]))
    else $error("mode 2 reload byte changed");

  AST_TOGGLE: assert property (
    ovf[0] && s_q.outCtl[DTC_OE0]
    |=> tmrOut[0] != $past(tmrOut[0]))
    else $error("output pin did not toggle");

  AST_TOGGLE1: assert property (
    ovf[2] && s_q.outCtl[DTC_OE1]
    |=> tmrOut[1] != $past(tmrOut[1]))
    else $error("output pin 1 did not toggle");

  AST_NO_TOGGLE0: assert property (
    !(ovf[0] && s_q.outCtl[DTC_OE0])
    |=> $stable(tmrOut[0]))
    else $error("output pin 0 moved without overflow");

  AST_NO_TOGGLE1: assert property (
    !(ovf[2] && s_q.outCtl[DTC_OE1])
    |=> $stable(tmrOut[1]))
    else $error("output pin 1 moved without overflow");

  AST_STOPPED: assert property (
    !split && !s_q.run[0] && !wrEn
    |=> $stable(s_q.cnt[0]))
    else $error("stopped timer 0 changed its count");

  AST_STOPPED1: assert property (
    !split && !s_q.run[1] && !wrEn
    |=> $stable(s_q.cnt[1]))
    else $error("stopped timer 1 changed its count");

  AST_GATE0: assert property (
    !split && s_q.timer_mode_select[DTC_GATE_BIT] && !s_q.gS2[0] && !wrEn
    |=> $stable(s_q.cnt[0]))
    else $error("timer 0 counted with gate low");

  AST_EXT_COUNT: assert property (
    !split && dtcMode(s_q.timer_mode_select, 0) == DTC_FREE16 &&
    s_q.timer_mode_select[DTC_CT_BIT] && !s_q.timer_mode_select[DTC_GATE_BIT] && s_q.run[0] &&
    fall[0] && !wrEn
    |=> s_q.cnt[0] == $past(s_q.cnt[0]) + 16'h0001)
    else $error("falling edge did not count");

  AST_DIV12_HOLD: assert property (
    !split && !s_q.timer_mode_select[DTC_CT_BIT] && !s_q.outCtl[DTC_X120] &&
    s_q.pre != DTC_PRE_LAST && !wrEn
    |=> $stable(s_q.cnt[0]))
    else $error("divided timer counted off the prescale tick");

  AST_RESERVED: assert property (
    pready && paddr == DTC_OFS_OUT && !pwrite
    |-> (prdata[7:0] & ~DTC_OUT_MASK) == DTC_RST8)
    else $error("reserved bits read nonzero");

  AST_OUT_MASK: assert property (
    (s_q.outCtl & ~DTC_OUT_MASK)
    == DTC_RST8)
    else $error("reserved output bits stored");

  AST_T1_STOP: assert property (
    dtcMode(s_q.timer_mode_select, 1) == DTC_SPLIT && !wrEn
    |=> $stable(s_q.cnt[1]))
    else $error("timer 1 counted in mode 3");

  AST_SPLIT_T1_RUN: assert property (
    split && dtcMode(s_q.timer_mode_select, 1) == DTC_RLD16 &&
    s_q.cnt[1] != DTC_MAX16 && s_q.outCtl[DTC_X121] && !wrEn
    |=> s_q.cnt[1] == $past(s_q.cnt[1]) + 16'h0001)
    else $error("timer 1 did not run by mode in split");

  AST_SPLIT_T1: assert property (
    split && !ovf[1] && !intAck[1] && !wrEn
    |=> s_q.flag[1] == $past(s_q.flag[1]))
    else $error("timer 1 set its flag in split mode");

  AST_SPLIT_LOW: assert property (
    split && !s_q.run[0] && !wrEn
    |=> $stable(s_q.cnt[0][7:0]))
    else $error("split low byte counted while stopped");

  AST_SPLIT_HIGH: assert property (
    split && !s_q.run[1] && !wrEn
    |=> $stable(s_q.cnt[0][15:8]))
    else $error("split high byte counted while stopped");

  AST_SPLIT_WRAP: assert property (
    split && ovf[1] && !wrEn
    |=> s_q.cnt[0][15:8] == DTC_RST8)
    else $error("split high byte did not wrap");

  COV_RLD16: cover property (dtcMode(s_q.timer_mode_select, 0) == DTC_RLD16 && ovf[0]);
  COV_SPLIT: cover property (split && ovf[1]);
  COV_EXT:   cover property (fall[0] && s_q.run[0]);
  COV_ERR:   cover property (pready && pslverr);
  COV_T1RL8: cover property (dtcMode(s_q.timer_mode_select, 1) == DTC_RLD8 && ovf[2]);

endmodule : dtc_timer_pair

// *** verification/dtc_pin_model.sv ***
`timescale 1ns/1ps
module dtc_pin_model (
  input  wire logic       clk,
  output logic      [1:0] cntPin,
  output logic      [1:0] gatePin
);
  initial begin
    cntPin  = 2'b11;
    gatePin = 2'b00;
  end
  // Levels held 3 clocks so the 2-flop sync never drops an edge
  task automatic fall(input int i, input int n);
    repeat (n) begin
      @(posedge clk) cntPin[i] <= 1'b0;
      repeat (3) @(posedge clk);
      cntPin[i] <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask : fall
  task automatic gate(input int i, input logic g);
    @(posedge clk) gatePin[i] <= g;
  endtask : gate
endmodule : dtc_pin_model

// *** verification/dual_timer_counter_block_tb.sv ***
`timescale 1ns/1ps
module dual_timer_counter_block_tb
  import dtc_pkg::*;
();
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, v, t;
  logic [31:0] pwdata, prdata;
  logic [1:0]  cntPin, gatePin, intAck, ovfFlag, tmrOut;
  int          mismatches, tests_run, cyc;

  dtc_timer_pair dut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cntPin(cntPin),
    .gatePin(gatePin), .intAck(intAck), .ovfFlag(ovfFlag),
    .tmrOut(tmrOut));
  dtc_pin_model pins (.clk(clk), .cntPin(cntPin), .gatePin(gatePin));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    v = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rc(input string n, input logic [7:0] a,
                    input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(n, e, v);
  endtask : rc

  task automatic waitFlag(input int i);
    int k;
    k = 0;
    while (ovfFlag[i] !== 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    chk("flag", 8'h01, {7'h0, ovfFlag[i]});
  endtask : waitFlag

  task automatic t_regs();
    rc("run", DTC_OFS_RUN, 8'h00);
    rc("mode", DTC_OFS_MODE, 8'h00);
    wr(DTC_OFS_OUT, 8'hFF);
    rc("outreg", DTC_OFS_OUT, 8'h33);
    rc("unmapped", 8'h1C, 8'h00);
    chk("slverr", 8'h01, {7'h0, err});
  endtask : t_regs

  task automatic t_free16();
    wr(DTC_OFS_MODE, 8'h01);
    wr(DTC_OFS_OUT, 8'h03);
    wr(DTC_OFS_TH0, 8'hFF);
    wr(DTC_OFS_TL0, 8'hFE);
    wr(DTC_OFS_RUN, 8'h10);
    waitFlag(0);
    chk("pin", 8'h01, {7'h0, tmrOut[0]});
    @(posedge clk) intAck <= 2'b01;
    @(posedge clk) intAck <= 2'b00;
    @(posedge clk);
    chk("ack", 8'h00, {7'h0, ovfFlag[0]});
    wr(DTC_OFS_RUN, 8'h00);
    rc("noreload", DTC_OFS_TH0, 8'h00);
    t = v;
    apb(1'b0, DTC_OFS_TL0, 8'h00);
    t = v;
    wr(DTC_OFS_RUN, 8'h10);
    apb(1'b0, DTC_OFS_TL0, 8'h00);
    chk("resume", 8'h01, {7'h0, v >= t && v < t + 8'h08});
    wr(DTC_OFS_RUN, 8'h00);
  endtask : t_free16

  task automatic t_rld16();
    wr(DTC_OFS_MODE, 8'h00);
    wr(DTC_OFS_TH0, 8'hFF);
    wr(DTC_OFS_TL0, 8'h00);
    rc("load", DTC_OFS_TH0, 8'hFF);
    wr(DTC_OFS_RUN, 8'h10);
    wr(DTC_OFS_TH0, 8'h12);
    wr(DTC_OFS_TL0, 8'h34);
    rc("runwr", DTC_OFS_TH0, 8'hFF);
    waitFlag(0);
    wr(DTC_OFS_RUN, 8'h00);
    rc("reload", DTC_OFS_TH0, 8'h12);
    wr(DTC_OFS_TL0, 8'h56);
    rc("stage", DTC_OFS_TH0, 8'h12);
    rc("lowonly", DTC_OFS_TL0, 8'h56);
  endtask : t_rld16

  task automatic t_rld8();
    wr(DTC_OFS_MODE, 8'h06);
    wr(DTC_OFS_TH0, 8'hF0);
    wr(DTC_OFS_TL0, 8'hFE);
    wr(DTC_OFS_RUN, 8'h10);
    pins.fall(0, 2);
    waitFlag(0);
    wr(DTC_OFS_RUN, 8'h00);
    rc("rl8", DTC_OFS_TL0, 8'hF0);
    rc("hold8", DTC_OFS_TH0, 8'hF0);
  endtask : t_rld8

  task automatic t_gate();
    wr(DTC_OFS_MODE, 8'h09);
    wr(DTC_OFS_OUT, 8'h01);
    wr(DTC_OFS_TL0, 8'h00);
    wr(DTC_OFS_RUN, 8'h10);
    repeat (20) @(posedge clk);
    rc("gatelow", DTC_OFS_TL0, 8'h00);
    pins.gate(0, 1'b1);
    repeat (20) @(posedge clk);
    apb(1'b0, DTC_OFS_TL0, 8'h00);
    chk("gatehigh", 8'h01, {7'h0, v != 8'h00});
    pins.gate(0, 1'b0);
    wr(DTC_OFS_RUN, 8'h00);
  endtask : t_gate

  task automatic t_div12();
    wr(DTC_OFS_MODE, 8'h01);
    wr(DTC_OFS_OUT, 8'h00);
    wr(DTC_OFS_TL0, 8'h00);
    wr(DTC_OFS_RUN, 8'h10);
    repeat (120) @(posedge clk);
    wr(DTC_OFS_RUN, 8'h00);
    apb(1'b0, DTC_OFS_TL0, 8'h00);
    chk("div12", 8'h01, {7'h0, v >= 8'h09 && v <= 8'h0B});
  endtask : t_div12

  task automatic t_split();
    wr(DTC_OFS_MODE, 8'h03);
    wr(DTC_OFS_OUT, 8'h11);
    wr(DTC_OFS_TH0, 8'hFE);
    wr(DTC_OFS_RUN, 8'h40);
    waitFlag(1);
    chk("lowidle", 8'h00, {7'h0, ovfFlag[0]});
    apb(1'b0, DTC_OFS_TL1, 8'h00);
    chk("t1runs", 8'h01, {7'h0, v != 8'h00});
    @(posedge clk) intAck <= 2'b10;
    @(posedge clk) intAck <= 2'b00;
    @(posedge clk);
    chk("ack1", 8'h00, {7'h0, ovfFlag[1]});
    wr(DTC_OFS_RUN, 8'h00);
    wr(DTC_OFS_MODE, 8'h20);
    wr(DTC_OFS_OUT, 8'h30);
    wr(DTC_OFS_TH1, 8'h00);
    wr(DTC_OFS_TL1, 8'hFF);
    wr(DTC_OFS_RUN, 8'h40);
    waitFlag(1);
    chk("pin1", 8'h01, {7'h0, tmrOut[1]});
    wr(DTC_OFS_RUN, 8'h00);
    rc("hold1", DTC_OFS_TH1, 8'h00);
  endtask : t_split

  initial begin
    nrst    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    intAck  = 2'b00;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_free16();
    t_rld16();
    t_rld8();
    t_gate();
    t_div12();
    t_split();
    finish_test();
  end
endmodule : dual_timer_counter_block_tb
